//--- hw/fsmc_consts.vh
// Constants for the footswitch mode controller: timing, encodings, reset values.
// Assumes a 200 MHz system clock; included by bare name.
`ifndef FSMC_CONSTS_VH
`define FSMC_CONSTS_VH

`define FSMC_CLK_MHZ        200
`define FSMC_HOLD_MS        2000
`define FSMC_HOLD_CYCLES    (`FSMC_HOLD_MS * 1000 * `FSMC_CLK_MHZ)
`define FSMC_DEBOUNCE_US    5000
`define FSMC_DEBOUNCE_CYCLES (`FSMC_DEBOUNCE_US * `FSMC_CLK_MHZ)
`define FSMC_MSG_MS         500
`define FSMC_MSG_CYCLES     (`FSMC_MSG_MS * 1000 * `FSMC_CLK_MHZ)
`define FSMC_NUM_SW         10
`define FSMC_LOAD_SW        5
`define FSMC_NUM_BANKS      10
`define FSMC_MODE_PRESET    1'b0
`define FSMC_MODE_PEDAL     1'b1
`define FSMC_MODE_FACTORY   `FSMC_MODE_PEDAL
`define FSMC_REF_DEFAULT    5'h00
`define FSMC_REF_LAST       5'h1E
`define FSMC_DISP_NORMAL    2'h0
`define FSMC_DISP_BYPASS    2'h1
`define FSMC_DISP_TUNER     2'h2
`define FSMC_ARROW_FLAT     2'h1
`define FSMC_ARROW_SHARP    2'h2
`define FSMC_ARROW_CENTRE   2'h3
`define FSMC_ARROW_NONE     2'h0

`endif

//--- hw/fsmc_controller.v
// Footswitch mode controller: preset/pedal-toggle operation, banks, bypass, tuner.
// Assumes switches synchronous to mclk and a non-volatile mode cell outside.
// Assumes raw contacts read high while pressed and low when released.
// Presets, effect state and display text live outside; this block emits strobes and codes.
`timescale 1ns/1ps
`include "fsmc_consts.vh"
module fsmc_controller #(
	parameter NUM_SW          = `FSMC_NUM_SW,
	parameter NUM_BANKS       = `FSMC_NUM_BANKS,
	parameter HOLD_CYCLES     = `FSMC_HOLD_CYCLES,
	parameter DEBOUNCE_CYCLES = `FSMC_DEBOUNCE_CYCLES,
	parameter MSG_CYCLES      = `FSMC_MSG_CYCLES
) (
	input  wire              mclk,
	input  wire              reset,
	input  wire [NUM_SW-1:0] foot_sw,
	input  wire              up_sw,
	input  wire              down_sw,
	input  wire              mode_btn,
	input  wire              ampcab_btn,
	input  wire              nv_valid,
	input  wire              nv_mode,
	input  wire              factory_restore,
	output reg               nv_write,
	output reg               nv_wdata,
	input  wire              knob1_step,
	input  wire              knob1_dir,
	input  wire              tone_sel,
	input  wire [5:0]        tone_index,
	input  wire [1:0]        pitch_state,
	input  wire [7:0]        expr_pos,
	input  wire              amp_loop_in,
	input  wire              stomp_loop_in,
	output reg               op_mode,
	output reg  [3:0]        bank,
	output reg  [3:0]        preset_slot,
	output reg               preset_load,
	output reg  [4:0]        effect_toggle,
	output reg               bypass,
	output reg               ampcab_bypass,
	output reg               ampcab_lamp,
	output reg               amp_loop_en,
	output reg               stomp_loop_en,
	output reg               tuner_on,
	output reg  [1:0]        disp_msg,
	output reg  [1:0]        tuner_arrows,
	output reg  [4:0]        tune_ref,
	output reg  [7:0]        tuner_volume,
	output reg               tone_load,
	output reg  [5:0]        tone_entry
);
	// Numbered switches, then Up, Down, mode and amp/cabinet buttons
	localparam NIN = NUM_SW + 4;
	// Sized copies of counts that meet 4-bit bank and switch indices
	localparam [31:0] LAST_BANK    = NUM_BANKS - 1;
	localparam [31:0] FIRST_TOGGLE = `FSMC_LOAD_SW;

	// Debounced levels and one-cycle press strobes, split by switch
	wire [NIN-1:0] lvl;
	wire [NIN-1:0] prs;
	wire           hold_fire;
	wire [NUM_SW-1:0] fs_press = prs[NUM_SW-1:0];
	wire           up_press   = prs[NUM_SW];
	wire           down_press = prs[NUM_SW+1];
	wire           mode_press = prs[NUM_SW+2];
	wire           amp_press  = prs[NUM_SW+3];

	// Debounce and press detection for all switches and buttons
	fsmc_debounce #(
		.WIDTH  (NIN),
		.CYCLES (DEBOUNCE_CYCLES)
	) u_debounce (
		.mclk  (mclk),
		.reset (reset),
		.raw   ({ampcab_btn, mode_btn, down_sw, up_sw, foot_sw}),
		.level (lvl),
		.press (prs)
	);

	// Only the active preset's switch starts a long press, and not while tuning
	wire hold_level = lvl[preset_slot] & ~tuner_on;

	// Long-press timer on the active preset's switch
	fsmc_hold_timer #(
		.CYCLES (HOLD_CYCLES)
	) u_hold (
		.mclk  (mclk),
		.reset (reset),
		.held  (hold_level),
		.fired (hold_fire)
	);

	// Lowest pressed footswitch wins: each stage passes on the one above unless pressed
	wire [NUM_SW:0]     any_chain;
	wire [4*NUM_SW+3:0] idx_chain;
	assign any_chain[NUM_SW]              = 1'b0;
	assign idx_chain[4*NUM_SW+3:4*NUM_SW] = 4'h0;
	genvar g;
	generate
		for (g = 0; g < NUM_SW; g = g + 1) begin : g_prio
			// Stage g: this switch if pressed, else what the stages above found
			localparam [31:0] IDX = g;
			assign any_chain[g]         = fs_press[g] | any_chain[g+1];
			assign idx_chain[4*g+3:4*g] = fs_press[g] ? IDX[3:0] : idx_chain[4*g+7:4*g+4];
		end
	endgenerate
	// Winner of the chain, and whether any numbered switch was pressed
	wire [3:0] sw_idx = idx_chain[3:0];
	wire       sw_any = any_chain[0];

	// Any footswitch, numbered or Up/Down, counts as a press for leaving the tuner
	wire any_foot = sw_any | up_press | down_press;

	// Preset operation, where Up/Down step banks and every switch loads
	wire in_preset = (op_mode == `FSMC_MODE_PRESET);

	// Does this switch load a preset in the current mode
	wire is_load = in_preset || (sw_idx < FIRST_TOGGLE[3:0]);

	// Power-up load done, bypass message still showing, and its timer
	reg        mode_loaded;
	reg        pend_bypass;
	reg [31:0] msg_count;

	// Operating mode, non-volatile load and store
	always @(posedge mclk) begin
		if (reset) begin
			op_mode     <= `FSMC_MODE_FACTORY;
			mode_loaded <= 1'b0;
			nv_write    <= 1'b0;
			nv_wdata    <= `FSMC_MODE_FACTORY;
		end else begin
			nv_write <= 1'b0;
			if (factory_restore) begin
				op_mode  <= `FSMC_MODE_FACTORY;
				nv_write <= 1'b1;
				nv_wdata <= `FSMC_MODE_FACTORY;
				mode_loaded <= 1'b1;
			end else if (!mode_loaded) begin
				mode_loaded <= 1'b1;
				op_mode     <= nv_valid ? nv_mode : `FSMC_MODE_FACTORY;
			end else if (mode_press) begin
				op_mode  <= ~op_mode;
				nv_write <= 1'b1;
				nv_wdata <= ~op_mode;
			end
		end
	end

	// Bank, preset, bypass and effect toggles
	always @(posedge mclk) begin
		if (reset) begin
			bank          <= 4'h0;
			preset_slot   <= 4'h0;
			preset_load   <= 1'b0;
			effect_toggle <= 5'h00;
			bypass        <= 1'b0;
		end else begin
			preset_load   <= 1'b0;
			effect_toggle <= 5'h00;
			if (tuner_on || hold_fire) begin
				// Presses in tuner only exit it; handled below
			end else if (sw_any) begin
				if (!is_load) begin
					effect_toggle <= 5'h01 << (sw_idx - FIRST_TOGGLE[3:0]);
				end else if (sw_idx == preset_slot) begin
					bypass <= ~bypass;
					preset_load <= bypass; // Reload the held preset on exit
				end else begin
					bypass      <= 1'b0;
					preset_slot <= sw_idx;
					preset_load <= 1'b1;
				end
			end else if (in_preset && up_press) begin
				bank <= (bank == LAST_BANK[3:0]) ? 4'h0 : bank + 4'h1;
				preset_load <= 1'b1;
			end else if (in_preset && down_press) begin
				bank <= (bank == 4'h0) ? LAST_BANK[3:0] : bank - 4'h1;
				preset_load <= 1'b1;
			end
		end
	end

	// Global amp/cabinet flag and lamp, independent of operating mode
	always @(posedge mclk) begin
		if (reset) begin
			ampcab_bypass <= 1'b0;
			ampcab_lamp   <= 1'b0;
		end else if (amp_press) begin
			ampcab_bypass <= ~ampcab_bypass;
			ampcab_lamp   <= ~ampcab_bypass;
		end
	end

	// Loop enables follow their own controls, never the bypass state
	always @(posedge mclk) begin
		if (reset) begin
			amp_loop_en   <= 1'b0;
			stomp_loop_en <= 1'b0;
		end else begin
			amp_loop_en   <= amp_loop_in;
			stomp_loop_en <= stomp_loop_in;
		end
	end

	// Tuner entry, messages and exit
	always @(posedge mclk) begin
		if (reset) begin
			tuner_on    <= 1'b0;
			pend_bypass <= 1'b0;
			msg_count   <= 32'h00000000;
			disp_msg    <= `FSMC_DISP_NORMAL;
		end else if (hold_fire) begin
			tuner_on    <= 1'b1;
			pend_bypass <= 1'b1;
			msg_count   <= 32'h00000000;
			disp_msg    <= `FSMC_DISP_BYPASS;
		end else if (tuner_on) begin
			if (any_foot) begin
				tuner_on    <= 1'b0;
				pend_bypass <= 1'b0;
				msg_count   <= 32'h00000000;
				disp_msg    <= `FSMC_DISP_NORMAL;
			end else begin
				if (pend_bypass) begin
					if (msg_count >= MSG_CYCLES - 1) begin
						pend_bypass <= 1'b0;
						disp_msg    <= `FSMC_DISP_TUNER;
					end else begin
						msg_count <= msg_count + 32'h00000001;
					end
				end
			end
		end
	end

	// Reference choice: the first knob steps it only while tuning
	always @(posedge mclk) begin
		if (reset) begin
			tune_ref <= `FSMC_REF_DEFAULT;
		end else if (tuner_on && !any_foot && knob1_step) begin
			if (knob1_dir && tune_ref != `FSMC_REF_LAST) begin
				tune_ref <= tune_ref + 5'h01;
			end else if (!knob1_dir && tune_ref != `FSMC_REF_DEFAULT) begin
				tune_ref <= tune_ref - 5'h01;
			end
		end
	end

	// Arrow pattern for the detected pitch: left when flat, right when sharp
	reg [1:0] next_arrows;
	always @* begin
		next_arrows = `FSMC_ARROW_NONE;
		case (pitch_state)
			2'h1:    next_arrows = `FSMC_ARROW_FLAT;
			2'h2:    next_arrows = `FSMC_ARROW_SHARP;
			2'h3:    next_arrows = `FSMC_ARROW_CENTRE;
			default: next_arrows = `FSMC_ARROW_NONE;
		endcase
	end

	// Tuner arrows and volume from the pedal while tuning
	always @(posedge mclk) begin
		if (reset) begin
			tuner_arrows <= `FSMC_ARROW_NONE;
			tuner_volume <= 8'h00;
		end else begin
			tuner_arrows <= tuner_on ? next_arrows : `FSMC_ARROW_NONE;
			tuner_volume <= tuner_on ? expr_pos : 8'h00;
		end
	end

	// Tone library: only the pre-amp group is reloaded
	always @(posedge mclk) begin
		if (reset) begin
			tone_load  <= 1'b0;
			tone_entry <= 6'h00;
		end else begin
			tone_load <= tone_sel & ~tuner_on;
			// Entries picked while tuning are dropped along with their strobe
			if (tone_sel && !tuner_on) begin
				tone_entry <= tone_index;
			end
		end
	end
endmodule // fsmc_controller

//--- hw/fsmc_debounce.v
// Debouncer and edge detector for one group of switch inputs, one per bit.
// Assumes inputs synchronous to mclk; emits a one-cycle press pulse per press.
`timescale 1ns/1ps
module fsmc_debounce #(
	parameter WIDTH  = 12,
	parameter CYCLES = 1000000
) (
	input  wire             mclk,
	input  wire             reset,
	input  wire [WIDTH-1:0] raw,
	output wire [WIDTH-1:0] level,
	output wire [WIDTH-1:0] press
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg [31:0] count;
			reg        stable;
			reg        pulse;
			// Accept a new level only once it has held for the whole window
			always @(posedge mclk) begin
				if (reset) begin
					count  <= 32'h00000000;
					stable <= 1'b0;
					pulse  <= 1'b0;
				end else begin
					pulse <= 1'b0;
					if (raw[i] == stable) begin
						count <= 32'h00000000;
					end else if (count >= CYCLES - 1) begin
						count  <= 32'h00000000;
						stable <= raw[i];
						pulse  <= raw[i]; // Rising edge only
					end else begin
						count <= count + 32'h00000001;
					end
				end
			end
			assign level[i] = stable;
			assign press[i] = pulse;
		end
	endgenerate
endmodule // fsmc_debounce

//--- hw/fsmc_hold_timer.v
// Long-press timer: pulses once when its input has stayed high for CYCLES.
// Assumes a debounced level input synchronous to mclk.
`timescale 1ns/1ps
module fsmc_hold_timer #(
	parameter CYCLES = 400000000
) (
	input  wire mclk,
	input  wire reset,
	input  wire held,
	output reg  fired
);
	reg [31:0] count;
	reg        done;

	// Count while held; fire once, rearm on release
	always @(posedge mclk) begin
		if (reset || !held) begin
			count <= 32'h00000000;
			done  <= 1'b0;
			fired <= 1'b0;
		end else if (!done && count >= CYCLES - 1) begin
			done  <= 1'b1;
			fired <= 1'b1;
		end else begin
			fired <= 1'b0;
			if (!done) begin
				count <= count + 32'h00000001;
			end
		end
	end
endmodule // fsmc_hold_timer

//--- tb/fsmc_performer.sv
// Performer model: steps on and releases panel switches one at a time.
// Assumes its task is entered just after a falling clock edge.
`timescale 1ns/1ps
module fsmc_performer #(
	parameter DB = 4
) (
	input  wire         mclk,
	output logic [13:0] keys
);
	initial keys = 14'h0000;
	// Hold one key for dwell cycles, then release and rest past the debounce
	task automatic tap(input int k, input int dwell);
		keys[k] = 1'b1;
		repeat (dwell) @(negedge mclk);
		keys[k] = 1'b0;
		repeat (DB + 6) @(negedge mclk); // Released switch reads low
	endtask
endmodule // fsmc_performer

//--- tb/fsmc_properties.sv
// Checker for the footswitch mode controller, watching its ports only.
// Assumes one clock mclk and a synchronous active-high reset.
`timescale 1ns/1ps
module fsmc_properties #(
	parameter MSG_CYCLES = 10
) (
	input wire       mclk,
	input wire       reset,
	input wire       nv_valid,
	input wire       nv_mode,
	input wire [1:0] pitch_state,
	input wire [7:0] expr_pos,
	input wire       amp_loop_in,
	input wire       op_mode,
	input wire [3:0] bank,
	input wire [3:0] preset_slot,
	input wire       preset_load,
	input wire [4:0] effect_toggle,
	input wire       ampcab_bypass,
	input wire       ampcab_lamp,
	input wire       amp_loop_en,
	input wire       tuner_on,
	input wire [1:0] disp_msg,
	input wire [1:0] tuner_arrows,
	input wire [4:0] tune_ref,
	input wire [7:0] tuner_volume
);
	localparam int MSG_HI = MSG_CYCLES + 3;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (reset);
	// Port relations over time
	a_lamp_flag: assert property (ampcab_lamp == ampcab_bypass)
		else $error("lamp differs from flag");
	a_loop_kept: assert property (!$past(reset) |-> amp_loop_en == $past(amp_loop_in))
		else $error("amp loop enable not passed through");
	a_mode_restore: assert property ($fell(reset) |=> op_mode == ($past(nv_valid) ? $past(nv_mode) : 1'b1))
		else $error("mode not restored at power-up");
	a_ref_default: assert property ($past(reset) |-> tune_ref == 5'h00)
		else $error("reference not at default");
	a_ref_tuner: assert property (!$past(reset) && !$past(tuner_on) |-> $stable(tune_ref))
		else $error("reference moved outside tuner");
	a_load_range: assert property (preset_load |-> preset_slot <= 4'h9 && bank <= 4'h9)
		else $error("slot or bank out of range");
	a_toggle_pedal: assert property (effect_toggle != 5'h00 |-> op_mode && $onehot(effect_toggle))
		else $error("effect toggled outside pedal-toggle");
	a_load_single: assert property (preset_load |=> !preset_load)
		else $error("load pulse too long");
	a_tuner_quiet: assert property (tuner_on |-> !preset_load && effect_toggle == 5'h00)
		else $error("preset action during tuner");
	a_tuner_msgs: assert property ($rose(tuner_on) |-> disp_msg == 2'h1 ##[1:MSG_HI] disp_msg == 2'h2)
		else $error("tuner message order wrong");
	a_tuner_follow: assert property (tuner_on && $past(tuner_on) && $stable(pitch_state) && $stable(expr_pos)
		|-> tuner_arrows == pitch_state && tuner_volume == expr_pos)
		else $error("arrows or volume not following");
	a_tuner_idle: assert property (!tuner_on && !$past(tuner_on) |-> tuner_arrows == 2'h0 && tuner_volume == 8'h00)
		else $error("arrows or volume outside tuner");
	// Main scenarios reached
	c_tuner: cover property ($rose(tuner_on));
	c_toggle: cover property (effect_toggle != 5'h00);
	c_load: cover property (preset_load && !op_mode);
endmodule // fsmc_properties
bind fsmc_controller fsmc_properties #(.MSG_CYCLES(MSG_CYCLES)) u_fsmc_properties (.mclk, .reset,
	.nv_valid, .nv_mode, .pitch_state, .expr_pos, .amp_loop_in, .op_mode, .bank, .preset_slot,
	.preset_load, .effect_toggle, .ampcab_bypass, .ampcab_lamp, .amp_loop_en, .tuner_on,
	.disp_msg, .tuner_arrows, .tune_ref, .tuner_volume);

//--- tb/tb.sv
// Bench for the footswitch mode controller, driving inputs on falling edges.
// Assumes shortened debounce, hold and message counts.
`timescale 1ns/1ps
module tb;
	logic        mclk = 1'b0, reset = 1'b1, nv_valid = 1'b0, nv_mode = 1'b1;
	logic        factory_restore = 1'b0, knob1_step = 1'b0, knob1_dir = 1'b1, tone_sel = 1'b0;
	logic        amp_loop_in = 1'b0, stomp_loop_in = 1'b0, seen_load, seen_nvw, seen_tone;
	logic [5:0]  tone_index = 6'h00;
	logic [1:0]  pitch_state = 2'h0;
	logic [7:0]  expr_pos = 8'h00;
	logic [4:0]  seen_tog;
	wire  [13:0] keys;
	wire  [4:0]  effect_toggle, tune_ref;
	wire  [3:0]  bank, preset_slot;
	wire  [1:0]  disp_msg, tuner_arrows;
	wire  [7:0]  tuner_volume;
	wire  [5:0]  tone_entry;
	wire         nv_write, nv_wdata, op_mode, preset_load, bypass, ampcab_bypass, ampcab_lamp;
	wire         amp_loop_en, stomp_loop_en, tuner_on, tone_load;
	int          n_mismatch = 0, compares = 0;
	fsmc_performer #(.DB(4)) u_fsmc_performer (.mclk, .keys);
	fsmc_controller #(.HOLD_CYCLES(50), .DEBOUNCE_CYCLES(4), .MSG_CYCLES(10)) u_fsmc_controller (
		.mclk, .reset, .foot_sw(keys[9:0]), .up_sw(keys[10]), .down_sw(keys[11]),
		.mode_btn(keys[12]), .ampcab_btn(keys[13]), .nv_valid, .nv_mode, .factory_restore,
		.nv_write, .nv_wdata, .knob1_step, .knob1_dir, .tone_sel, .tone_index, .pitch_state,
		.expr_pos, .amp_loop_in, .stomp_loop_in, .op_mode, .bank, .preset_slot, .preset_load,
		.effect_toggle, .bypass, .ampcab_bypass, .ampcab_lamp, .amp_loop_en, .stomp_loop_en,
		.tuner_on, .disp_msg, .tuner_arrows, .tune_ref, .tuner_volume, .tone_load, .tone_entry);
	// Clock at 200 MHz
	initial forever #2.5 mclk = ~mclk;
	// Catch one-cycle pulses between checks
	always @(posedge mclk) begin
		seen_load <= seen_load | preset_load;
		seen_nvw <= seen_nvw | nv_write;
		seen_tone <= seen_tone | tone_load;
		seen_tog <= seen_tog | effect_toggle;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic tap(input int k, input int dwell);
		{seen_load, seen_nvw, seen_tone, seen_tog} <= 8'h00;
		u_fsmc_performer.tap(k, dwell);
	endtask
	task automatic pulse(ref logic sig);
		sig = 1'b1;
		@(negedge mclk);
		sig = 1'b0;
		repeat (3) @(negedge mclk);
	endtask
	task automatic summarize();
		$display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// Cut a hang short
	initial begin
		#100000;
		n_mismatch++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		repeat (4) @(negedge mclk);
		chk(op_mode, 8'h01, "factory mode");
		chk(tune_ref, 8'h00, "reference");
		tap(6, 8); chk(seen_tog, 8'h02, "toggle six");
		tap(1, 8); chk(preset_slot, 8'h01, "pedal load");
		chk(seen_load, 8'h01, "pedal load pulse");
		tap(10, 8); chk(bank, 8'h00, "up ignored");
		$display("test pedal-toggle done");
		tap(12, 8); chk(op_mode, 8'h00, "mode swap");
		chk({seen_nvw, nv_wdata}, 8'h02, "mode stored");
		tap(7, 8); chk(preset_slot, 8'h07, "preset load");
		chk(seen_tog, 8'h00, "no toggle");
		tap(10, 8); chk(bank, 8'h01, "bank up");
		tap(11, 8); tap(11, 8); chk(bank, 8'h09, "bank wrap");
		$display("test preset done");
		{amp_loop_in, stomp_loop_in} = 2'b11;
		tap(7, 8); chk(bypass, 8'h01, "bypass on");
		chk({amp_loop_en, stomp_loop_en}, 8'h03, "loops kept");
		tap(7, 8); chk({bypass, preset_slot}, 8'h07, "same exits");
		chk(seen_load, 8'h01, "reload");
		tap(7, 8); tap(3, 8); chk({bypass, preset_slot}, 8'h03, "other exits");
		$display("test bypass done");
		tap(13, 8); chk({ampcab_bypass, ampcab_lamp}, 8'h03, "ampcab on");
		tap(12, 8); chk({op_mode, ampcab_bypass}, 8'h03, "ampcab kept");
		tap(13, 8); chk({ampcab_bypass, ampcab_lamp}, 8'h00, "ampcab off");
		$display("test ampcab done");
		tap(3, 70); chk({tuner_on, disp_msg}, 8'h06, "tuner entry");
		expr_pos = 8'h5A;
		pulse(knob1_step); chk(tune_ref, 8'h01, "knob ref");
		chk(tuner_volume, 8'h5A, "volume");
		for (int p = 1; p < 4; p++) begin
			pitch_state = p[1:0];
			repeat (3) @(negedge mclk);
			chk(tuner_arrows, p[7:0], "arrows");
		end
		tap(9, 8); chk({tuner_on, tuner_arrows}, 8'h00, "tuner exit");
		pulse(knob1_step); chk(tune_ref, 8'h01, "knob ignored");
		tap(3, 70); tap(10, 8); chk(tuner_on, 8'h00, "tuner exit by up");
		$display("test tuner done");
		tone_index = 6'h15;
		pulse(tone_sel); chk({seen_tone, tone_entry}, 8'h55, "tone load");
		tap(12, 8); pulse(factory_restore); chk(op_mode, 8'h01, "restore");
		{nv_valid, nv_mode, reset} = 3'b101;
		repeat (16) @(negedge mclk);
		reset = 1'b0;
		repeat (4) @(negedge mclk);
		chk(op_mode, 8'h00, "power-up mode");
		$display("test storage done");
		summarize();
	end
endmodule // tb
